// ===== verilog/fan_and_supply_monitor.v
// Purpose: fan speed and supply-good monitor behind a byte-wide I/O port
// Assumes: bus strobes synchronous and one cycle long; base jumpers static
// Notes: strobe divisor and mode words follow a subset of timer behaviour
`timescale 1ns/1ps
`include "env_monitor_regs.vh"
module fan_and_supply_monitor #(
	parameter CLK_HZ = 100000000,
	parameter OSC_HZ = `OSC_HZ
) (
	input wire sys_clk,
	input wire resetn,
	input wire [9:0] io_addr,
	input wire io_rd,
	input wire io_wr,
	input wire [7:0] io_wdata,
	input wire [5:0] base_jumper,
	output reg [7:0] io_rdata,
	output wire io_sel,
	input wire fan_one_pulse,
	input wire fan_two_pulse,
	input wire supply_good,
	output wire buzzer_off,
	output wire irq5,
	output wire irq6,
	output wire irq7
);
	// Oscillator tick rate, scaled into sys_clk steps (phase accumulator)
	localparam [31:0] OSC_STEP = OSC_HZ / 100;
	localparam [31:0] OSC_WRAP = CLK_HZ / 100;

	reg [31:0] phase_q;
	reg [`PRESCALE_BITS-1:0] prescale_q;
	reg [15:0] div_hold_q;
	reg [15:0] div_count_q;
	reg div_lsb_next_q;
	reg div_run_q;
	reg strobe_n_q;
	reg [7:0] control_q;
	reg [7:0] limit_q;
	reg [2:0] status_q;
	reg irq_pulse_q;
	reg strobe_prev_q;
	reg [31:0] phase_d;
	reg osc_tick;
	wire timebase_en;
	wire in_window;
	wire [2:0] ofs;
	wire wr_hit;
	wire soft_reset;
	wire card_rst_n;
	wire mode_wr;
	wire [1:0] mode_sel;
	wire [1:0] mode_rw;
	wire one_out;
	wire two_out;
	wire strobe_rise;
	wire [2:0] status_d;

	// Match against the jumper value as given, with no inversion
	function match_base;
		input [9:0] addr;
		input [5:0] jump;
		begin
			match_base = (addr[9:4] == jump) && (addr[3] == 1'b0) &&
				(addr[2:0] != 3'h7);
		end
	endfunction

	// Decode of seven consecutive byte offsets
	assign in_window = match_base(io_addr, base_jumper); // RULE_24
	assign ofs = io_addr[2:0];
	assign io_sel = in_window & (io_rd | io_wr);
	assign wr_hit = in_window & io_wr;

	// Software reset acts one cycle later and wipes itself too
	assign soft_reset = control_q[`CTL_SWRESET];
	assign card_rst_n = resetn & ~soft_reset; // RULE_22

	// Fractional oscillator model from sys_clk
	always @* begin
		phase_d = phase_q + OSC_STEP;
		osc_tick = 1'b0;
		if (phase_d >= OSC_WRAP) begin
			phase_d = phase_d - OSC_WRAP;
			osc_tick = 1'b1;
		end
	end

	// Fixed 14-bit prescaler gives the ~873.912 Hz strobe timebase
	always @(posedge sys_clk) begin
		if (!card_rst_n) begin
			phase_q <= 32'h0000_0000;
			prescale_q <= {`PRESCALE_BITS{1'b0}};
		end else begin
			phase_q <= phase_d;
			if (osc_tick)
				prescale_q <= prescale_q + 1'b1; // RULE_02
		end
	end
	assign timebase_en = osc_tick & (&prescale_q); // RULE_02

	// Mode word layout: counter select and read/write format
	assign mode_wr = wr_hit & (ofs == `OFS_COUNTER_MODE);
	assign mode_sel = io_wdata[`MODE_SEL_HI:`MODE_SEL_LO];
	assign mode_rw = io_wdata[`MODE_RW_HI:`MODE_RW_LO];

	// Rate generator: low byte then high byte, runs after the high byte
	always @(posedge sys_clk) begin
		if (!card_rst_n) begin
			div_hold_q <= 16'h0000;
			div_count_q <= 16'h0000;
			div_lsb_next_q <= 1'b1;
			div_run_q <= 1'b0;
			strobe_n_q <= 1'b1;
		end else begin
			if (mode_wr && mode_sel == 2'b00 && mode_rw != 2'b00) begin
				div_lsb_next_q <= 1'b1;
				div_run_q <= 1'b0;
				strobe_n_q <= 1'b1;
			end else if (wr_hit && ofs == `OFS_STROBE_DIVISOR) begin
				if (div_lsb_next_q) begin
					div_hold_q[7:0] <= io_wdata;
					div_lsb_next_q <= 1'b0;
				end else begin
					div_hold_q[15:8] <= io_wdata;
					div_count_q <= {io_wdata, div_hold_q[7:0]}; // RULE_01
					div_lsb_next_q <= 1'b1;
					div_run_q <= 1'b1;
				end
			end else if (timebase_en && div_run_q) begin
				// Count of zero acts as 65536, the widest interval
				if (div_count_q == 16'h0002) begin
					strobe_n_q <= 1'b0; // RULE_03
					div_count_q <= 16'h0001;
				end else if (div_count_q == 16'h0001) begin
					strobe_n_q <= 1'b1; // RULE_03
					div_count_q <= div_hold_q; // RULE_01
				end else begin
					div_count_q <= div_count_q - 16'h0001; // RULE_05
				end
			end
		end
	end

	// Each countdown sees only the mode words that select it (01 or 10)
	tach_countdown u_first_tach_countdown (
		.sys_clk(sys_clk),
		.resetn(card_rst_n),
		.mode_wr(mode_wr && mode_sel == 2'b01 && mode_rw != 2'b00),
		.count_wr(wr_hit && ofs == `OFS_FAN_ONE_COUNT),
		.wr_data(io_wdata),
		.fan_pulse(fan_one_pulse),
		.lockout(control_q[`CTL_FORCE_FAN1]),
		.strobe_n(strobe_n_q), // RULE_04
		.count_out_q(one_out)
	);

	tach_countdown u_second_tach_countdown (
		.sys_clk(sys_clk),
		.resetn(card_rst_n),
		.mode_wr(mode_wr && mode_sel == 2'b10 && mode_rw != 2'b00),
		.count_wr(wr_hit && ofs == `OFS_FAN_TWO_COUNT),
		.wr_data(io_wdata),
		.fan_pulse(fan_two_pulse),
		.lockout(control_q[`CTL_FORCE_FAN2]),
		.strobe_n(strobe_n_q), // RULE_04
		.count_out_q(two_out)
	);

	// Control and limit copies; limit tracks either fan count write
	always @(posedge sys_clk) begin
		if (!card_rst_n) begin
			control_q <= `RESET_BYTE; // RULE_23
			limit_q <= `RESET_BYTE; // RULE_23
		end else begin
			if (wr_hit && ofs == `OFS_CARD_CONTROL)
				control_q <= {io_wdata[7:1], 1'b0}; // RULE_19
			if (wr_hit && (ofs == `OFS_FAN_ONE_COUNT ||
				ofs == `OFS_FAN_TWO_COUNT))
				limit_q <= io_wdata; // RULE_06
		end
	end

	// Status sampled on the strobe rising edge, the end of the low pulse
	assign strobe_rise = strobe_n_q & ~strobe_prev_q;
	assign status_d = {~one_out, ~two_out,
		~supply_good | control_q[`CTL_FORCE_SUPPLY]}; // RULE_14 RULE_20

	always @(posedge sys_clk) begin
		if (!card_rst_n) begin
			strobe_prev_q <= 1'b1;
			status_q <= 3'b000;
			irq_pulse_q <= 1'b0;
		end else begin
			strobe_prev_q <= strobe_n_q;
			irq_pulse_q <= 1'b0;
			if (strobe_rise) begin
				status_q <= status_d; // RULE_14 RULE_04
				irq_pulse_q <= (status_d != status_q); // RULE_16
			end
		end
	end

	// Edge request steered to one of three lines, none when zero
	assign irq5 = irq_pulse_q &
		(control_q[`CTL_IRQSEL_HI:`CTL_IRQSEL_LO] == 2'b01); // RULE_17
	assign irq6 = irq_pulse_q &
		(control_q[`CTL_IRQSEL_HI:`CTL_IRQSEL_LO] == 2'b10); // RULE_17
	assign irq7 = irq_pulse_q &
		(control_q[`CTL_IRQSEL_HI:`CTL_IRQSEL_LO] == 2'b11); // RULE_17
	assign buzzer_off = control_q[`CTL_BUZZER_OFF]; // RULE_18

	// Registered read data; write-only offsets read zero
	always @(posedge sys_clk) begin
		if (!resetn) begin
			io_rdata <= 8'h00;
		end else if (io_rd && in_window) begin
			case (ofs)
			`OFS_LIMIT_READBACK: io_rdata <= limit_q; // RULE_06
			`OFS_FAULT_STATUS: io_rdata <= {status_q, 5'h00}; // RULE_21
			`OFS_CARD_CONTROL: io_rdata <= control_q;
			default: io_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// ===== verilog/env_monitor_regs.vh
// Purpose: offsets, fields, reset values and timing counts of the monitor
// Assumes: byte-wide I/O port, offsets relative to the card base
// Notes: included by both design files
// Functional notes
// RULE_01: Strobe counter is 16-bit mode 2 divider.
// RULE_02: Strobe clock is oscillator over 14-bit divider.
// RULE_03: Strobe low one input clock every N.
// RULE_04: Strobe gates countdowns and latches status.
// RULE_05: Strobe interval spans about 2.29 ms-75 s.
// RULE_06: Last fan limit kept for read-back.
// RULE_07: Software loads both countdowns with same limit.
// RULE_08: Mode word resets counter, output high; count loads.
// RULE_09: Strobe rising edge loads count and arms.
// RULE_10: First clock fall starts count, output low.
// RULE_11: Armed counter decrements each clock fall.
// RULE_12: Output high on zero, else stays low.
// RULE_13: Strobe XOR fan pulses forms counter clock.
// RULE_14: Next strobe latches inverted outputs, bits 7,6.
// RULE_15: Fan pulses divided by eight first.
// RULE_16: Interrupt edge on any status bit change.
// RULE_17: Interrupt routed to line 5, 6 or 7.
// RULE_18: Control bit silences supply alarm sounder.
// RULE_19: Control bits force faults, reset card.
// RULE_20: Error bit 5 high on supply fault.
// RULE_21: Unused error bits read zero.
// RULE_22: Top control bit resets card, clears itself.
// RULE_23: Reset clears control and limit registers.
// RULE_24: Seven byte offsets decoded from jumper base.
`ifndef ENV_MONITOR_REGS_VH
`define ENV_MONITOR_REGS_VH
`define OFS_STROBE_DIVISOR 3'h0
`define OFS_FAN_ONE_COUNT 3'h1
`define OFS_FAN_TWO_COUNT 3'h2
`define OFS_COUNTER_MODE 3'h3
`define OFS_LIMIT_READBACK 3'h4
`define OFS_FAULT_STATUS 3'h5
`define OFS_CARD_CONTROL 3'h6
`define CTL_SWRESET 7
`define CTL_BUZZER_OFF 6
`define CTL_FORCE_FAN1 5
`define CTL_FORCE_FAN2 4
`define CTL_FORCE_SUPPLY 3
`define CTL_IRQSEL_HI 2
`define CTL_IRQSEL_LO 1
`define ERR_FAN1 7
`define ERR_FAN2 6
`define ERR_SUPPLY 5
`define RESET_BYTE 8'h00
`define MODE_SEL_HI 7
`define MODE_SEL_LO 6
`define MODE_RW_HI 5
`define MODE_RW_LO 4
// Bus oscillator of 14.31818 MHz, in Hz, and its 14-bit prescaler
`define OSC_HZ 14318180
`define PRESCALE_BITS 14
`define TACH_DIV_BITS 3
`endif

// ===== verilog/tach_countdown.v
// Purpose: one 8-bit mode 1 countdown fed by a conditioned fan pulse
// Assumes: all inputs synchronous to sys_clk; strobe is active low
// Notes: counter clock is strobe XOR the divided fan pulse train
`timescale 1ns/1ps
`include "env_monitor_regs.vh"
module tach_countdown (
	input wire sys_clk,
	input wire resetn,
	input wire mode_wr,
	input wire count_wr,
	input wire [7:0] wr_data,
	input wire fan_pulse,
	input wire lockout,
	input wire strobe_n,
	output reg count_out_q
);
	reg [`TACH_DIV_BITS-1:0] div_q;
	reg fan_prev_q;
	reg cnt_clk_prev_q;
	reg strobe_prev_q;
	reg [7:0] hold_q;
	reg [7:0] count_q;
	reg armed_q;
	reg running_q;
	wire fan_rise;
	wire tach_div;
	wire cnt_clk;
	wire cnt_fall;
	wire gate_rise;

	// Divide-by-eight of the fan pulse train; lockout freezes it
	assign fan_rise = fan_pulse & ~fan_prev_q & ~lockout;
	assign tach_div = div_q[`TACH_DIV_BITS-1]; // RULE_15
	// Strobe low pulse toggles the clock so a dead fan still starts
	assign cnt_clk = tach_div ^ ~strobe_n; // RULE_13
	assign cnt_fall = cnt_clk_prev_q & ~cnt_clk;
	assign gate_rise = strobe_n & ~strobe_prev_q;

	// Edge history and prescaler
	always @(posedge sys_clk) begin
		if (!resetn) begin
			div_q <= {`TACH_DIV_BITS{1'b0}};
			fan_prev_q <= 1'b0;
			cnt_clk_prev_q <= 1'b0;
			strobe_prev_q <= 1'b1;
		end else begin
			fan_prev_q <= fan_pulse;
			if (fan_rise)
				div_q <= div_q + 1'b1; // RULE_15
			cnt_clk_prev_q <= cnt_clk;
			strobe_prev_q <= strobe_n;
		end
	end

	// Mode 1 one-shot; a gate edge also takes a clock fall of its cycle
	always @(posedge sys_clk) begin
		if (!resetn) begin
			hold_q <= 8'h00;
			count_q <= 8'h00;
			armed_q <= 1'b0;
			running_q <= 1'b0;
			count_out_q <= 1'b1;
		end else if (mode_wr) begin
			armed_q <= 1'b0; // RULE_08
			running_q <= 1'b0;
			count_out_q <= 1'b1; // RULE_08
		end else begin
			if (count_wr)
				hold_q <= wr_data; // RULE_08
			// A still fan leaves the strobe edge as the only clock fall,
			// so a fall in the gate cycle starts the count at once
			if (gate_rise) begin
				count_q <= hold_q; // RULE_09
				armed_q <= 1'b1; // RULE_09
				running_q <= cnt_fall; // RULE_13
				if (cnt_fall)
					count_out_q <= 1'b0; // RULE_10
			end else if (cnt_fall && armed_q && !running_q) begin
				running_q <= 1'b1; // RULE_10
				count_out_q <= 1'b0; // RULE_10
			end else if (cnt_fall && running_q) begin
				count_q <= count_q - 8'h01; // RULE_11
				if (count_q == 8'h01) begin
					count_out_q <= 1'b1; // RULE_12
					running_q <= 1'b0;
					armed_q <= 1'b0;
				end
			end
		end
	end
endmodule

// ===== verif/fan_and_supply_monitor_asserts.sv
// Purpose: port-level checks of the fan and supply monitor
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
module fan_and_supply_monitor_asserts (
	input wire sys_clk,
	input wire resetn,
	input wire [9:0] io_addr,
	input wire io_rd,
	input wire io_wr,
	input wire [7:0] io_wdata,
	input wire [5:0] base_jumper,
	input wire [7:0] io_rdata,
	input wire io_sel,
	input wire buzzer_off,
	input wire irq5,
	input wire irq6,
	input wire irq7
);
	// Accepted accesses and their offset
	wire rd_hit = io_rd && io_sel;
	wire wr_hit = io_wr && io_sel;
	wire [2:0] ofs = io_addr[2:0];
	wire any_irq = irq5 || irq6 || irq7;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_sel;
		io_sel == ((io_rd || io_wr) && io_addr[9:4] == base_jumper
			&& io_addr[3:0] < 4'h7);
	endproperty
	a_sel: assert property (p_sel) else $error("bad select");
	property p_irq_one;
		$onehot0({irq7, irq6, irq5});
	endproperty
	a_irq_one: assert property (p_irq_one) else $error("two irqs");
	property p_irq_pulse;
		any_irq |=> !any_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
	property p_buzz;
		wr_hit && ofs == 3'h6 && !io_wdata[7] |=> buzzer_off == $past(io_wdata[6]);
	endproperty
	a_buzz: assert property (p_buzz) else $error("buzzer bit");
	property p_swrst;
		wr_hit && ofs == 3'h6 && io_wdata[7] |-> ##3 !buzzer_off;
	endproperty
	a_swrst: assert property (p_swrst) else $error("soft reset");
	property p_rd_zero;
		rd_hit && !ofs[2] |=> io_rdata == 8'h00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("wo read");
	property p_err_unused;
		rd_hit && ofs == 3'h5 |=> io_rdata[4:0] == 5'h00;
	endproperty
	a_err_unused: assert property (p_err_unused) else $error("unused");
	property p_limit;
		wr_hit && ofs == 3'h1 ##2 rd_hit && ofs == 3'h4
			|=> io_rdata == $past(io_wdata, 3);
	endproperty
	a_limit: assert property (p_limit) else $error("limit copy");
	property p_rd_hold;
		!rd_hit |=> $stable(io_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
	c_irq5: cover property (irq5);
	c_irq6: cover property (irq6);
	c_err_rd: cover property (rd_hit && ofs == 3'h5);
endmodule

bind fan_and_supply_monitor fan_and_supply_monitor_asserts
	fan_and_supply_monitor_asserts_inst (.sys_clk(sys_clk), .resetn(resetn),
	.io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
	.base_jumper(base_jumper), .io_rdata(io_rdata), .io_sel(io_sel),
	.buzzer_off(buzzer_off), .irq5(irq5), .irq6(irq6), .irq7(irq7));

// ===== verif/isa_host_model.sv
// Purpose: host side of the byte-wide I/O port
// Assumes: tasks are entered at a falling edge of sys_clk
// Notes: released address lines show inverted values; io_wdata keeps its last value
`timescale 1ns/1ps
module isa_host_model (
	input wire sys_clk,
	input wire [7:0] io_rdata,
	output reg [9:0] io_addr,
	output reg io_rd,
	output reg io_wr,
	output reg [7:0] io_wdata
);
	// Idle bus at time zero
	initial begin
		io_addr = 10'h000;
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_wdata = 8'h00;
	end
	// One-cycle write, then a quiet cycle so strobes never merge
	task wr(input [9:0] a, input [7:0] d);
		begin
			io_addr = a;
			io_wdata = d;
			io_wr = 1'b1;
			@(negedge sys_clk);
			io_wr = 1'b0;
			io_addr = ~a;
			@(negedge sys_clk);
		end
	endtask
	// Read data is taken a full cycle after the strobe edge
	task rd(input [9:0] a, output [7:0] d);
		begin
			io_addr = a;
			io_rd = 1'b1;
			@(negedge sys_clk);
			io_rd = 1'b0;
			io_addr = ~a;
			@(negedge sys_clk);
			d = io_rdata;
		end
	endtask
endmodule

// ===== verif/test_fan_and_supply_monitor.sv
// Purpose: self-checking bench of the fan and supply monitor
// Assumes: card base 0x200, oscillator raised to one tick per cycle
// Notes: strobe divisor 2 gives a strobe every 32768 cycles
`timescale 1ns/1ps
module test_fan_and_supply_monitor;
	reg sys_clk = 1'b0;
	reg resetn = 1'b0;
	reg fan_one_pulse = 1'b0;
	reg fan_two_pulse = 1'b0;
	reg supply_good = 1'b0;
	reg [5:0] fcnt = 6'h00;
	reg [7:0] rv;
	integer fail_count = 0;
	integer n_checks = 0;
	integer cyc = 0;
	wire [9:0] io_addr;
	wire io_rd, io_wr, io_sel, buzzer_off, irq5, irq6, irq7;
	wire [7:0] io_wdata, io_rdata;
	fan_and_supply_monitor #(.CLK_HZ(100000000), .OSC_HZ(100000000))
		fan_and_supply_monitor_inst (.sys_clk(sys_clk), .resetn(resetn),
		.io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
		.io_wdata(io_wdata), .base_jumper(6'h20), .io_rdata(io_rdata),
		.io_sel(io_sel), .fan_one_pulse(fan_one_pulse),
		.fan_two_pulse(fan_two_pulse), .supply_good(supply_good),
		.buzzer_off(buzzer_off), .irq5(irq5), .irq6(irq6), .irq7(irq7));
	isa_host_model isa_host_model_inst (.sys_clk(sys_clk),
		.io_rdata(io_rdata), .io_addr(io_addr), .io_rd(io_rd),
		.io_wr(io_wr), .io_wdata(io_wdata));
	always #5 sys_clk = ~sys_clk;
	// Fan one toggles every 64 cycles; fan two stays still as a stall
	always @(negedge sys_clk) begin
		fcnt <= fcnt + 6'h01;
		if (fcnt == 6'h3f)
			fan_one_pulse <= ~fan_one_pulse;
	end
	task check(input [7:0] seen, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks=%0d errors=%0d", n_checks, fail_count);
			if (fail_count == 0 && n_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// Bounded wait for a line; then only that line may be high
	task wait_irq(input [2:0] m);
		integer i;
		begin
			i = 0;
			while (({irq7, irq6, irq5} & m) == 3'b000 && i < 40000) begin
				@(negedge sys_clk);
				i = i + 1;
			end
			check({5'h00, irq7, irq6, irq5}, {5'h00, m});
		end
	endtask
	task t_regs;
		begin
			isa_host_model_inst.rd(10'h206, rv);
			check(rv, 8'h00);
			isa_host_model_inst.rd(10'h204, rv);
			check(rv, 8'h00);
			isa_host_model_inst.rd(10'h205, rv);
			check(rv, 8'h00);
			isa_host_model_inst.wr(10'h206, 8'h42);
			isa_host_model_inst.wr(10'h246, 8'h00);
			isa_host_model_inst.wr(10'h207, 8'h00);
			isa_host_model_inst.rd(10'h206, rv);
			check(rv, 8'h42);
			check({7'h00, buzzer_off}, 8'h01);
			isa_host_model_inst.rd(10'h200, rv);
			check(rv, 8'h00);
		end
	endtask
	task t_cfg;
		begin
			isa_host_model_inst.wr(10'h203, 8'h52);
			isa_host_model_inst.wr(10'h203, 8'h92);
			isa_host_model_inst.wr(10'h203, 8'h34);
			isa_host_model_inst.wr(10'h200, 8'h02);
			isa_host_model_inst.wr(10'h200, 8'h00);
			isa_host_model_inst.wr(10'h201, 8'h04);
			isa_host_model_inst.rd(10'h204, rv);
			check(rv, 8'h04);
			isa_host_model_inst.wr(10'h202, 8'h04);
			isa_host_model_inst.wr(10'h206, 8'h02);
			check({7'h00, buzzer_off}, 8'h00);
		end
	endtask
	// First strobe sees only the supply fault; second adds the stalled fan
	// while the supply is good again but its fault is forced
	task t_status;
		begin
			wait_irq(3'b001);
			isa_host_model_inst.rd(10'h205, rv);
			check(rv, 8'h20);
			supply_good = 1'b1;
			isa_host_model_inst.wr(10'h206, 8'h0c);
			wait_irq(3'b010);
			isa_host_model_inst.rd(10'h205, rv);
			check(rv, 8'h60);
			isa_host_model_inst.rd(10'h206, rv);
			check(rv, 8'h0c);
		end
	endtask
	task t_swreset;
		begin
			isa_host_model_inst.wr(10'h206, 8'hc0);
			isa_host_model_inst.rd(10'h206, rv);
			check(rv, 8'h00);
			isa_host_model_inst.rd(10'h204, rv);
			check(rv, 8'h00);
			isa_host_model_inst.rd(10'h205, rv);
			check(rv, 8'h00);
			check({7'h00, buzzer_off}, 8'h00);
		end
	endtask
	// Hang guard, well above two strobe periods
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			fail_count = fail_count + 1;
			test_done;
		end
	end
	initial begin
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		@(negedge sys_clk);
		t_regs;
		t_cfg;
		t_status;
		t_swreset;
		test_done;
	end
endmodule
